// ### rtl/dpls_pkg.sv
/*
 * constants of the dual pixel serializer: frame layout, timing, drive field layout.
 * assumes a 125 MHz system clock and a pixel clock of at most 8 MHz sampled by it.
 */
package dpls_pkg;
    // ==========================================
    // frame geometry
    localparam int PIX_W = 30;             // bits of one rgb pixel
    localparam int CTRL_W = 5;             // hsync, vsync, de, user0, user1
    localparam int GROUP_W = 35;           // pixel plus control per port group
    localparam int LANES = 10;             // serial data lanes, 0-4 odd, 5-9 even
    localparam int LANES_GROUP = 5;        // lanes per port group
    localparam int BITS_LANE = 7;          // serial bits per lane per frame
    localparam int WORD_W = 70;            // bits per frame over all lanes
    localparam logic [2:0] LAST_BIT = 3'h6;
    // forwarded clock shape over the seven bit slots
    localparam logic [6:0] CLK_PATTERN = 7'h0F;

    // ==========================================
    // timing
    localparam int CLK_PERIOD_NS = 8;      // system clock period
    localparam int BIT_TIME_NS = 16;       // least time one serial bit stands
    localparam int BIT_CYCLES = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] BIT_LAST = 4'(BIT_CYCLES - 1);

    // ==========================================
    // drive setting field positions
    localparam int EVEN_SWING_BIT = 5;
    localparam int ODD_SWING_BIT = 4;
    localparam int EVEN_OFFS_LSB = 2;
    localparam int ODD_OFFS_LSB = 0;
    localparam logic [5:0] DRIVE_RESET = 6'h00;
    localparam logic [1:0] COUNT_FULL = 2'h2;
endpackage

// ### rtl/dpls_serializer.sv
/*
 * dual pixel video serializer: samples pins, buffers two words, shifts ten lanes.
 * assumes config inputs come from logic on clk; pixel pins and the pixel clock do not.
 */
`timescale 1ns/1ps

// How it works
// - two pixels plus controls onto ten lanes
// - seventy bits per frame, seven per lane
// - single mode uses odd lanes only
// - dual mode sends second pixel on even lanes
// - edge select pin picks rising or falling
// - swing and offset reduced by drive settings
// - sample point shifted after the pixel edge
// - odd pixel, even group and output lanes individually disabled
// - power down low stops all serializing
// - drive register bits swing five four, offsets
module dpls_serializer (
    // system
    input wire logic clk,
    input wire logic reset,
    // video source pins
    input wire logic pixel_clock_in,
    input wire logic input_edge_select,
    input wire logic power_down_n,
    input wire logic [29:0] pixel_odd,
    input wire logic [29:0] pixel_even,
    input wire logic hsync,
    input wire logic vsync,
    input wire logic data_enable,
    input wire logic [1:0] user_ctrl,
    output logic pixel_ready,
    // configuration from the serial port logic
    input wire logic dual_pixel_mode,
    input wire logic [1:0] sample_delay,
    input wire logic [1:0] input_group_enable,
    input wire logic [9:0] output_lane_enable,
    input wire logic [5:0] drive_config,
    // link toward the panel receiver
    input wire logic link_ready,
    output logic [9:0] serial_out,
    output logic [1:0] fwd_clock_out,
    output logic [2:0] odd_port_drive_setting,
    output logic [2:0] even_port_drive_setting
);
    // ==========================================
    // state
    typedef struct packed {
        logic clk_s1;              // pixel clock synchroniser, first stage
        logic clk_s2;              // pixel clock synchroniser, second stage
        logic clk_s3;              // previous clock level for edge finding
        logic edge_s1;
        logic edge_s2;
        logic pd_s1;
        logic pd_s2;
        logic [64:0] data_s1;      // pins: ctrl, even, odd
        logic [64:0] data_s2;
        logic armed;               // sample point pending
        logic [1:0] dcnt;          // cycles left to the sample point
        logic [69:0] b0;           // buffer head
        logic [69:0] b1;           // buffer second entry
        logic [1:0] count;         // buffer occupancy
        logic [69:0] shift;        // word on the lanes
        logic frame_active;
        logic frame_dual;          // mode latched at frame load
        logic [2:0] bit_idx;
        logic [3:0] bit_cnt;
        logic [9:0] ser;
        logic [1:0] fclk;
        logic [5:0] drive;
    } dpls_state_t;

    dpls_state_t st_reg;
    dpls_state_t st_next;
    logic sel_edge;                // chosen pixel clock edge seen
    logic capture_now;             // pins sampled this cycle
    logic push;                    // captured word enters buffer
    logic frame_end;               // last cycle of last bit slot
    logic load;                    // buffer head moves to the lanes
    logic [69:0] new_word;

    // ==========================================
    // functions
    // builds the frame word from pins, honouring mode and input group enables
    function automatic logic [69:0] build_word(input logic [64:0] d, input logic dual,
                                               input logic [1:0] gen);
        logic [34:0] odd_g;
        logic [34:0] even_g;
        odd_g = {d[64:60], gen[0] ? d[29:0] : 30'h00000000};
        even_g = (dual && gen[1]) ? {d[64:60], d[59:30]} : 35'h000000000;
        return {even_g, odd_g};
    endfunction

    // picks the current bit of every lane, masked by lane enable
    function automatic logic [9:0] lanes(input logic [69:0] w, input logic [2:0] idx,
                                         input logic [9:0] en, input logic dual);
        logic [9:0] r;
        r = 10'h000;
        for (int l = 0; l < dpls_pkg::LANES; l++) begin
            r[l] = w[l * dpls_pkg::BITS_LANE + int'(idx)] & en[l];
        end
        if (!dual) begin
            r[9:5] = 5'h00;
        end
        return r;
    endfunction

    // ==========================================
    // combinational helpers
    assign sel_edge = st_reg.edge_s2 ? (st_reg.clk_s2 & ~st_reg.clk_s3)
                                     : (~st_reg.clk_s2 & st_reg.clk_s3);
    assign capture_now = st_reg.pd_s2 &&
        ((sel_edge && sample_delay == 2'h0) || (st_reg.armed && st_reg.dcnt == 2'h1));
    assign push = capture_now && st_reg.count != dpls_pkg::COUNT_FULL;
    assign frame_end = st_reg.frame_active && st_reg.bit_idx == dpls_pkg::LAST_BIT &&
                       st_reg.bit_cnt == dpls_pkg::BIT_LAST;
    assign load = st_reg.pd_s2 && link_ready && st_reg.count != 2'h0 &&
                  (!st_reg.frame_active || frame_end);
    assign new_word = build_word(st_reg.data_s2, dual_pixel_mode, input_group_enable);
    assign pixel_ready = st_reg.count != dpls_pkg::COUNT_FULL;

    // ==========================================
    // next state
    always_comb begin
        st_next = st_reg;
        // synchronisers: first stage read only by the second
        st_next.clk_s1 = pixel_clock_in;
        st_next.clk_s2 = st_reg.clk_s1;
        st_next.clk_s3 = st_reg.clk_s2;
        st_next.edge_s1 = input_edge_select;
        st_next.edge_s2 = st_reg.edge_s1;
        st_next.pd_s1 = power_down_n;
        st_next.pd_s2 = st_reg.pd_s1;
        st_next.data_s1 = {user_ctrl, data_enable, vsync, hsync, pixel_even, pixel_odd};
        st_next.data_s2 = st_reg.data_s1;
        // sample point delay after the chosen edge
        if (sel_edge && sample_delay != 2'h0) begin
            st_next.armed = 1'b1;
            st_next.dcnt = sample_delay;
        end else if (st_reg.armed) begin
            st_next.dcnt = st_reg.dcnt - 2'h1;
            st_next.armed = st_reg.dcnt != 2'h1;
        end
        // two entry buffer
        if (load && push) begin
            st_next.b0 = (st_reg.count == 2'h1) ? new_word : st_reg.b1;
            st_next.b1 = new_word;
        end else if (load) begin
            st_next.b0 = st_reg.b1;
            st_next.count = st_reg.count - 2'h1;
        end else if (push) begin
            if (st_reg.count == 2'h0) begin
                st_next.b0 = new_word;
            end else begin
                st_next.b1 = new_word;
            end
            st_next.count = st_reg.count + 2'h1;
        end
        // serial bit timing
        if (load) begin
            st_next.shift = st_reg.b0;
            st_next.frame_active = 1'b1;
            st_next.frame_dual = dual_pixel_mode;
            st_next.bit_idx = 3'h0;
            st_next.bit_cnt = 4'h0;
        end else if (frame_end) begin
            st_next.frame_active = 1'b0;
        end else if (st_reg.frame_active) begin
            if (st_reg.bit_cnt == dpls_pkg::BIT_LAST) begin
                st_next.bit_cnt = 4'h0;
                st_next.bit_idx = st_reg.bit_idx + 3'h1;
            end else begin
                st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
            end
        end
        // power down drops everything in flight
        if (!st_reg.pd_s2) begin
            st_next.armed = 1'b0;
            st_next.count = 2'h0;
            st_next.frame_active = 1'b0;
            st_next.drive = st_reg.drive;
        end else begin
            st_next.drive = drive_config;
        end
        // lane outputs follow the next state so they change with the bit slot
        if (st_next.frame_active) begin
            st_next.ser = lanes(st_next.shift, st_next.bit_idx, output_lane_enable,
                                st_next.frame_dual);
            st_next.fclk[0] = dpls_pkg::CLK_PATTERN[st_next.bit_idx];
            st_next.fclk[1] = dpls_pkg::CLK_PATTERN[st_next.bit_idx] & st_next.frame_dual;
        end else begin
            st_next.ser = 10'h000;
            st_next.fclk = 2'h0;
        end
    end

    // ==========================================
    // state register
    always_ff @(posedge clk) begin
        if (reset) begin
            st_reg <= '0;
            st_reg.drive <= dpls_pkg::DRIVE_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================
    // outputs
    assign serial_out = st_reg.ser;
    assign fwd_clock_out = st_reg.fclk;
    assign odd_port_drive_setting = {st_reg.drive[dpls_pkg::ODD_SWING_BIT],
        st_reg.drive[dpls_pkg::ODD_OFFS_LSB +: 2]};
    assign even_port_drive_setting = {st_reg.drive[dpls_pkg::EVEN_SWING_BIT],
        st_reg.drive[dpls_pkg::EVEN_OFFS_LSB +: 2]};

    // ==========================================
    // assertions
    sequence frame_body_s;
        st_reg.frame_active [*7] ##1 st_reg.frame_active [*7];
    endsequence

    // the edge cycle and two quiet cycles after it, then the late capture
    sequence delayed_capture_s;
        !capture_now [*3] ##1 capture_now;
    endsequence

    // a power down cuts the frame on purpose, so it aborts the check
    frame_length_a: assert property (@(posedge clk) disable iff (reset || !st_reg.pd_s2)
        load |=> frame_body_s)
        else $error("frame shorter than seven bit slots");

    single_even_a: assert property (@(posedge clk) disable iff (reset)
        !st_reg.frame_dual |-> serial_out[9:5] == 5'h00 && fwd_clock_out[1] == 1'b0)
        else $error("even lanes active in single pixel mode");

    dual_even_a: assert property (@(posedge clk) disable iff (reset)
        push && dual_pixel_mode && input_group_enable[1] && st_reg.count == 2'h0 && !load
        |=> st_reg.b0[64:35] == $past(st_reg.data_s2[59:30]))
        else $error("second pixel not stored for even lanes");

    // an empty buffer must take the word seen on the selected edge
    edge_capture_a: assert property (@(posedge clk) disable iff (reset)
        st_reg.pd_s2 && sel_edge && sample_delay == 2'h0 && st_reg.count == 2'h0
        |=> st_reg.count == 2'h1)
        else $error("no capture on selected edge");

    sample_shift_a: assert property (@(posedge clk) disable iff (reset || !st_reg.pd_s2)
        sel_edge && sample_delay == 2'h3 && !st_reg.armed |-> delayed_capture_s)
        else $error("capture not three cycles after edge");

    // every lane masked in the cycle before stays low
    lane_off_a: assert property (@(posedge clk) disable iff (reset)
        (serial_out & ~$past(output_lane_enable)) == 10'h000)
        else $error("disabled lane toggles");

    power_down_a: assert property (@(posedge clk) disable iff (reset)
        !st_reg.pd_s2 |=> serial_out == 10'h000 && !st_reg.frame_active && st_reg.count == 2'h0)
        else $error("serializing during power down");

    drive_bits_a: assert property (@(posedge clk) disable iff (reset)
        st_reg.pd_s2 |=> even_port_drive_setting == {$past(drive_config[5]),
        $past(drive_config[3:2])} && odd_port_drive_setting[2] == $past(drive_config[4]))
        else $error("drive setting fields misplaced");

    ctrl_frame_a: assert property (@(posedge clk) disable iff (reset)
        push && st_reg.count == 2'h0 && !load |=> st_reg.b0[34:30] == $past(st_reg.data_s2[64:60]))
        else $error("controls not stored with pixel");

    fwd_clock_a: assert property (@(posedge clk) disable iff (reset)
        st_reg.frame_active |-> fwd_clock_out[0] == dpls_pkg::CLK_PATTERN[st_reg.bit_idx])
        else $error("forwarded clock shape wrong");
endmodule // dpls_serializer

// ### sim/dpls_panel_rx.sv
/* panel receiver model: rebuilds each 70-bit word and clock shape from the lanes.
 * assumes lanes and forwarded clocks change only on clk, each slot two cycles. */
`timescale 1ns/1ps
module dpls_panel_rx (
    // system
    input wire logic clk,
    input wire logic reset,
    // link from the serializer
    input wire logic [9:0] serial_out,
    input wire logic [1:0] fwd_clock_out,
    output logic link_ready,
    // bench side
    input wire logic hold_off,
    output logic [69:0] rx_word,
    output logic [13:0] rx_shape,
    output logic rx_valid,
    output int rx_count
);
    logic prev_reg; // last odd clock level
    logic busy_reg; // inside a frame
    logic [3:0] cnt_reg; // cycle count in frame
    logic start; // odd clock rise opens a frame
    logic grab; // first cycle of a slot
    logic [2:0] slot; // slot being taken
    assign link_ready = ~hold_off; // bench asks for a stall
    assign start = fwd_clock_out[0] & ~prev_reg;
    assign grab = start | (busy_reg & ~cnt_reg[0]);
    assign slot = start ? 3'h0 : cnt_reg[3:1];
    // ==========================================
    // take seven slots per lane, lsb first
    always_ff @(posedge clk) begin
        rx_valid <= 1'h0;
        prev_reg <= fwd_clock_out[0];
        if (reset) begin
            busy_reg <= 1'h0;
            rx_count <= 0;
        end else begin
            if (grab) begin
                for (int l = 0; l < 10; l++) rx_word[7 * l + slot] <= serial_out[l];
                rx_shape[slot] <= fwd_clock_out[0];
                rx_shape[7 + slot] <= fwd_clock_out[1];
            end
            if (start) begin
                busy_reg <= 1'h1;
                cnt_reg <= 4'h1;
            end else if (busy_reg) begin
                cnt_reg <= cnt_reg + 4'h1;
                if (cnt_reg == 4'hD) begin // frame of fourteen cycles complete
                    busy_reg <= 1'h0;
                    rx_valid <= 1'h1;
                    rx_count <= rx_count + 1;
                end
            end
        end
    end
endmodule // dpls_panel_rx

// ### sim/dual_pixel_lvds_serializer_bench.sv
/* bench of the dual pixel serializer: one task per scenario, words judged at the panel.
 * assumes the package, the serializer and the panel model are compiled first. */
`timescale 1ns/1ps
module dual_pixel_lvds_serializer_bench;
    logic clk = 1'h0;
    logic reset = 1'h1;
    logic pixel_clock_in = 1'h0;
    logic input_edge_select = 1'h1;
    logic power_down_n = 1'h1;
    logic [29:0] pixel_odd = 30'h0;
    logic [29:0] pixel_even = 30'h0;
    logic hsync = 1'h0;
    logic vsync = 1'h0;
    logic data_enable = 1'h0;
    logic [1:0] user_ctrl = 2'h0;
    logic dual_pixel_mode = 1'h0;
    logic [1:0] sample_delay = 2'h0;
    logic [1:0] input_group_enable = 2'h3;
    logic [9:0] output_lane_enable = 10'h3FF;
    logic [5:0] drive_config = 6'h00;
    logic hold_off = 1'h0;
    logic pixel_ready, link_ready, rx_valid;
    logic [9:0] serial_out;
    logic [1:0] fwd_clock_out;
    logic [2:0] odd_port_drive_setting, even_port_drive_setting;
    logic [69:0] rx_word;
    logic [13:0] rx_shape;
    int rx_count;
    int failures = 0;
    int tests_run = 0;
    logic [70:0] exp_q[$]; // {dual, word} still owed by the link
    logic [70:0] got;
    logic [5:0] drv_tab [4] = '{6'h15, 6'h2A, 6'h39, 6'h06};
    dpls_serializer uut (.clk, .reset, .pixel_clock_in, .input_edge_select, .power_down_n,
        .pixel_odd, .pixel_even, .hsync, .vsync, .data_enable, .user_ctrl, .pixel_ready,
        .dual_pixel_mode, .sample_delay, .input_group_enable, .output_lane_enable,
        .drive_config, .link_ready, .serial_out, .fwd_clock_out, .odd_port_drive_setting,
        .even_port_drive_setting);
    dpls_panel_rx panel (.clk, .reset, .serial_out, .fwd_clock_out, .link_ready, .hold_off,
        .rx_word, .rx_shape, .rx_valid, .rx_count);
    // ==========================================
    // clock and shared tasks
    initial forever #4 clk = ~clk;
    task check(input string what, input logic [69:0] seen, input logic [69:0] want);
        tests_run++;
        if (seen !== want) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, want, seen);
        end
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    function logic [69:0] expect_word(logic [29:0] po, logic [29:0] pe, logic [4:0] ct);
        logic [69:0] w;
        w[34:0] = {ct, input_group_enable[0] ? po : 30'h0};
        w[69:35] = (dual_pixel_mode && input_group_enable[1]) ? {ct, pe} : 35'h0;
        for (int l = 0; l < 10; l++) if (!output_lane_enable[l]) w[7 * l +: 7] = 7'h00;
        return w;
    endfunction
    // one pixel clock period; pins hold around the selected edge, junk after it
    task send(input logic [29:0] po, input logic [29:0] pe, input logic [4:0] ct, input bit keep);
        @(negedge clk);
        if (keep) exp_q.push_back({dual_pixel_mode, expect_word(po, pe, ct)});
        {user_ctrl, data_enable, vsync, hsync} = ct;
        pixel_odd = po;
        pixel_even = pe;
        #22.5 pixel_clock_in = input_edge_select;
        repeat (7) @(negedge clk);
        {user_ctrl, data_enable, vsync, hsync} = ~ct;
        pixel_odd = ~po;
        pixel_even = ~pe;
        #13 pixel_clock_in = ~input_edge_select; // phase after the selected edge 62.5 ns
        #40;
    endtask
    task wait_rx;
        for (int i = 0; i < 400 && exp_q.size() > 0; i++) @(negedge clk);
        if (exp_q.size() > 0) begin
            failures++;
            $display("ERROR words owed expected 0 seen %0d", exp_q.size());
            give_verdict;
        end
    endtask
    task do_reset;
        @(negedge clk);
        reset = 1'h1;
        pixel_clock_in = ~input_edge_select;
        repeat (4) @(negedge clk);
        reset = 1'h0;
        repeat (6) @(negedge clk);
    endtask
    // every word at the panel against the owed queue
    always @(negedge clk) if (rx_valid === 1'h1) begin
        if (exp_q.size() == 0) check("spare word", 70'h1, 70'h0);
        else begin
            got = exp_q.pop_front();
            check("lane word", rx_word, got[69:0]);
            check("clock shape", 70'(rx_shape), 70'({got[70] ? dpls_pkg::CLK_PATTERN : 7'h00,
                dpls_pkg::CLK_PATTERN}));
        end
    end
    // ==========================================
    // scenarios
    task t_drive;
        for (int i = 0; i < 4; i++) begin
            @(negedge clk) drive_config = drv_tab[i];
            repeat (4) @(negedge clk);
            check("odd drive", 70'(odd_port_drive_setting),
                70'({drv_tab[i][4], drv_tab[i][1:0]}));
            check("even drive", 70'(even_port_drive_setting),
                70'({drv_tab[i][5], drv_tab[i][3:2]}));
        end
        $display("drive settings done");
    endtask
    task t_modes;
        send(30'h12345678, 30'h3FFFFFFF, 5'h15, 1'h1);
        send(30'h0ACE1357, 30'h15555555, 5'h0A, 1'h1);
        wait_rx;
        dual_pixel_mode = 1'h1;
        sample_delay = 2'h3; // late sampling point
        send(30'h2468ACE0, 30'h13579BDF, 5'h13, 1'h1);
        send(30'h3C3C3C3C, 30'h03C3C3C3, 5'h0C, 1'h1);
        wait_rx;
        input_group_enable = 2'h1; // even pixel off, lanes masked
        output_lane_enable = 10'h2F3;
        send(30'h3FFFFFFF, 30'h3FFFFFFF, 5'h00, 1'h1);
        wait_rx;
        input_group_enable = 2'h3;
        output_lane_enable = 10'h3FF;
        $display("single, dual and enables done");
    endtask
    task t_falling;
        input_edge_select = 1'h0; // capture on the falling edge
        sample_delay = 2'h0;
        do_reset;
        send(30'h1F0F0F0F, 30'h20F0F0F0, 5'h11, 1'h1);
        wait_rx;
        input_edge_select = 1'h1;
        do_reset;
        $display("falling edge done");
    endtask
    task t_stall;
        hold_off = 1'h1;
        send(30'h11111111, 30'h22222222, 5'h01, 1'h1);
        send(30'h33333333, 30'h04444444, 5'h02, 1'h1);
        send(30'h05555555, 30'h06666666, 5'h03, 1'h0);
        check("ready while full", 70'(pixel_ready), 70'h0);
        hold_off = 1'h0;
        wait_rx;
        check("ready when drained", 70'(pixel_ready), 70'h1);
        $display("stall done");
    endtask
    task t_power;
        int n;
        n = rx_count;
        power_down_n = 1'h0;
        repeat (5) @(negedge clk);
        send(30'h0BADBEEF, 30'h0FEEDFAC, 5'h1F, 1'h0);
        repeat (40) @(negedge clk);
        check("lanes powered down", 70'(serial_out), 70'h0);
        check("words powered down", 70'(rx_count), 70'(n));
        power_down_n = 1'h1;
        repeat (6) @(negedge clk);
        send(30'h01020304, 30'h05060708, 5'h09, 1'h1);
        wait_rx;
        $display("power down done");
    endtask
    initial begin
        do_reset;
        t_drive;
        t_modes;
        t_falling;
        t_stall;
        t_power;
        give_verdict;
    end
endmodule // dual_pixel_lvds_serializer_bench
